// >>> hw/chain_device_end.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// One chained slave: shifts its frame, then hands off.
module chain_device_end
   import chain_link_pkg::*;
(
   input wire logic i_core_clk, // System clock.
   input wire logic i_rst, // Asynchronous reset.
   input wire logic i_clock_source_select, // 1 uses serial clock.
   input wire logic [DEVICE_BITS-1:0] i_frame_data, // Data to send.
   chain_link_if.device_end link, // Chain pins.
   output logic [WORD_BITS-1:0] o_command, // First command word of its slot.
   output logic o_command_valid, // Command pulse.
   output logic o_sample_strobe // Output data rate pulse.
);
   logic [2:0] sclk_s, cs_s, sync_s, ext_s;
   logic [1:0] mosi_s;
   logic [BIT_CNT_W-1:0] bit_cnt, next_bit_cnt;
   logic [DEVICE_BITS-1:0] shreg, next_shreg;
   logic [WORD_BITS-1:0] rx, next_rx;
   logic done, next_done;
   logic [OSR_CNT_W-1:0] osr_cnt, next_osr_cnt;
   logic mod_tick, sclk_rise, counting, selected, sync_edge;

   // Two-stage synchronisers, third stage for edge detection.
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sclk_s <= 3'h0; cs_s <= 3'h7; sync_s <= 3'h7;
         ext_s <= 3'h0; mosi_s <= 2'h0;
      end
      else
      begin
         sclk_s <= {sclk_s[1:0], link.sclk};
         cs_s <= {cs_s[1:0], link.chip_select_n};
         sync_s <= {sync_s[1:0], link.frame_sync};
         ext_s <= {ext_s[1:0], link.external_clock_input};
         mosi_s <= {mosi_s[0], link.mosi};
      end
   end

   assign sclk_rise = sclk_s[1] & ~sclk_s[2];
   assign selected = ~cs_s[1] & ~done;
   // A rise seen in the same cycle as the select is ignored.
   // The host counts no rise launched before it selected us.
   assign counting = selected & ~cs_s[2];
   assign sync_edge = ~sync_s[1] & sync_s[2];
   // Modulator tick from either clock source.
   assign mod_tick = i_clock_source_select ? sclk_rise :
                     (ext_s[1] & ~ext_s[2]);

   // Shift, command capture, hand-off and rate divider.
   always_comb
   begin
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_rx = rx;
      next_done = done;
      next_osr_cnt = osr_cnt;
      if (cs_s[1])
      begin
         next_bit_cnt = '0;
         next_done = 1'b0;
         next_shreg = i_frame_data;
      end
      else if (counting && sclk_rise)
      begin
         // Capture the command bit, then present the next data bit.
         next_rx = {rx[WORD_BITS-2:0], mosi_s[1]};
         next_shreg = {shreg[DEVICE_BITS-2:0], 1'b0};
         next_bit_cnt = bit_cnt + 1'b1;
         if (bit_cnt == BIT_CNT_W'(DEVICE_BITS - 1))
            next_done = 1'b1;
      end
      if (sync_edge)
         next_osr_cnt = '0;
      else if (mod_tick)
         next_osr_cnt = (osr_cnt == OSR_CNT_W'(OVERSAMPLING_RATIO - 1)) ?
                        '0 : osr_cnt + 1'b1;
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         bit_cnt <= '0; shreg <= '0; rx <= '0;
         done <= 1'b0; osr_cnt <= '0;
         o_command <= '0; o_command_valid <= 1'b0;
         o_sample_strobe <= 1'b0;
      end
      else
      begin
         bit_cnt <= next_bit_cnt; shreg <= next_shreg; rx <= next_rx;
         done <= next_done; osr_cnt <= next_osr_cnt;
         o_command_valid <= counting && sclk_rise &&
                            bit_cnt == BIT_CNT_W'(WORD_BITS - 1);
         if (counting && sclk_rise && bit_cnt == BIT_CNT_W'(WORD_BITS - 1))
            o_command <= {rx[WORD_BITS-2:0], mosi_s[1]};
         o_sample_strobe <= mod_tick &&
                            osr_cnt == OSR_CNT_W'(OVERSAMPLING_RATIO - 1);
      end
   end

   // Hand-off low selects next device once this one is done.
   assign link.handoff_n = ~(~cs_s[1] & done);
   assign link.miso_o = shreg[DEVICE_BITS-1];
   assign link.miso_oe = selected;
endmodule
`default_nettype wire

// >>> hw/chain_host_end.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// Host master: free-running clock, frame select, sync.
module chain_host_end
   import chain_link_pkg::*;
(
   input wire logic i_core_clk, // System clock.
   input wire logic i_rst, // Asynchronous reset.
   input wire logic i_start, // Start one frame pulse.
   input wire logic [FRAME_BITS-1:0] i_tx, // Commands, all slots.
   chain_link_if.host_end link, // Chain pins.
   output logic [FRAME_BITS-1:0] o_rx, // Received frame.
   output logic o_busy, // Frame in progress.
   output logic o_done // Frame complete pulse.
);
   logic [1:0] div, next_div;
   logic sclk, next_sclk, miso_a, miso_b;
   logic [11:0] cnt, next_cnt;
   logic [FRAME_BITS-1:0] tx, next_tx, rx, next_rx;
   logic busy, next_busy;

   // Clock divider, frame counter, shift registers.
   always_comb
   begin
      next_div = div + 1'b1;
      next_sclk = sclk;
      next_cnt = cnt;
      next_tx = tx;
      next_rx = rx;
      next_busy = busy;
      if (div == 2'(SCLK_HALF_CYCLES - 1))
      begin
         next_div = '0;
         next_sclk = ~sclk;
         if (busy && !sclk)
         begin
            next_rx = {rx[FRAME_BITS-2:0], miso_b};
            next_cnt = cnt + 1'b1;
            // The device answers one link clock late, so the first
            // sample is a dummy and the frame takes one extra rise.
            if (cnt == 12'(FRAME_BITS))
               next_busy = 1'b0;
         end
         else if (busy && sclk && cnt != '0)
            next_tx = {tx[FRAME_BITS-2:0], 1'b0};
      end
      if (!busy && i_start)
      begin
         next_busy = 1'b1;
         next_cnt = '0;
         next_tx = i_tx;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         div <= '0; sclk <= 1'b0; cnt <= '0; tx <= '0; rx <= '0;
         busy <= 1'b0; o_rx <= '0; o_done <= 1'b0;
         miso_a <= 1'b0; miso_b <= 1'b0;
      end
      else
      begin
         div <= next_div; sclk <= next_sclk; cnt <= next_cnt;
         tx <= next_tx; rx <= next_rx; busy <= next_busy;
         miso_a <= link.miso_oe & link.miso_o;
         miso_b <= miso_a;
         o_done <= busy & ~next_busy;
         if (busy && !next_busy)
            o_rx <= next_rx;
      end
   end

   assign o_busy = busy;
   assign link.sclk = sclk;
   assign link.mosi = tx[FRAME_BITS-1];
   assign link.chip_select_n = ~busy;
   assign link.frame_sync = ~busy;
endmodule
`default_nettype wire

// >>> hw/chain_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// Serial chain wiring between host and one device.
interface chain_link_if;
   logic sclk;
   logic mosi;
   logic frame_sync;
   logic chip_select_n;
   logic handoff_n;
   logic miso_o;
   logic miso_oe;
   logic external_clock_input;
   modport device_end (input sclk, input mosi, input frame_sync,
      input chip_select_n, input external_clock_input,
      output handoff_n, output miso_o, output miso_oe);
   modport host_end (output sclk, output mosi, output frame_sync,
      output chip_select_n, input miso_o, input miso_oe);
endinterface
`default_nettype wire

// >>> hw/chain_link_pkg.sv
package chain_link_pkg;
   // =====================================================
   // Frame layout and timing
   localparam int WORD_BITS = 24;
   localparam int WORDS_PER_DEVICE = 6;
   localparam int DEVICE_BITS = WORD_BITS * WORDS_PER_DEVICE;
   localparam int CHAIN_DEVICES = 4;
   localparam int FRAME_BITS = DEVICE_BITS * CHAIN_DEVICES;
   localparam int OVERSAMPLING_RATIO = 256;
   localparam int SCLK_HALF_CYCLES = 2;
   localparam int BIT_CNT_W = 10;
   localparam int OSR_CNT_W = 9;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
endpackage

// >>> sim/chain_link_checker.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// Watches the host side of the chain wiring.
module chain_link_checker
   import chain_link_pkg::*;
(
   input wire logic i_core_clk, // Clock.
   input wire logic i_rst, // Reset.
   input wire logic sclk, // Serial clock.
   input wire logic frame_sync, // Sync.
   input wire logic chip_select_n, // Select.
   input wire logic miso_oe // Data drive.
);
   int lo_cnt;
   int next_lo_cnt;
   // Counts the cycles of the current selected frame.
   always_comb next_lo_cnt = chip_select_n ? 0 : lo_cnt + 1;
   always_ff @(posedge i_core_clk or posedge i_rst)
      if (i_rst) lo_cnt <= 0;
      else lo_cnt <= next_lo_cnt;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   chk_sync_with_select:
      assert property ($fell(chip_select_n) |-> !frame_sync) else $error("sync");
   chk_sclk_half_period:
      assert property ($changed(sclk) |=> $stable(sclk) ##1 $changed(sclk))
      else $error("sclk period");
   chk_select_min_low:
      assert property ($fell(chip_select_n) |=> !chip_select_n[*8])
      else $error("short select");
   chk_frame_span_min:
      assert property ($rose(chip_select_n) |->
         $past(lo_cnt) >= FRAME_BITS * 2 * SCLK_HALF_CYCLES)
      else $error("frame short");
   chk_frame_span_max:
      assert property (lo_cnt < FRAME_BITS * 2 * SCLK_HALF_CYCLES + 64)
      else $error("frame long");
   chk_data_released:
      assert property (chip_select_n[*8] |-> !miso_oe) else $error("drive");
   chk_drive_in_frame:
      assert property ($rose(miso_oe) |-> !chip_select_n) else $error("oe");
   chk_idle_gap_held:
      assert property ($rose(chip_select_n) |=> chip_select_n[*8])
      else $error("idle gap");
endmodule
`default_nettype wire

// >>> sim/tb_adc_slave_daisy_chain_link.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// Host and four devices chained on one shared bus.
module tb_adc_slave_daisy_chain_link import chain_link_pkg::*;;
   logic i_core_clk = 0, i_rst = 1, i_start = 0, src = 1, ext = 0, flt = 0;
   logic [FRAME_BITS-1:0] tx = '0, rx, r;
   logic [DEVICE_BITS-1:0] fd [4];
   logic [WORD_BITS-1:0] cmd [4], got [4];
   logic [3:0] cv, ss, oe, mo;
   logic [4:0] cs;
   logic busy, done;
   int seed = 32'h0000_f90d, n_mismatch = 0, n_tests = 0;
   int gap = 0, last_gap = 0, t = 0;
   chain_link_if ifh ();
   chain_link_if dv [4] ();
   initial forever #12.5 i_core_clk = ~i_core_clk;
   // A released data line shows a changing level, not the last bit.
   assign cs[0] = ifh.chip_select_n;
   assign ifh.miso_oe = |oe;
   assign ifh.miso_o = |oe ? |(oe & mo) : flt;
   for (genvar g = 0; g < 4; g++)
   begin : gen_dev
      assign dv[g].sclk = ifh.sclk;
      assign dv[g].mosi = ifh.mosi;
      assign dv[g].frame_sync = ifh.frame_sync;
      assign dv[g].chip_select_n = cs[g];
      assign dv[g].external_clock_input = ext;
      assign cs[g+1] = dv[g].handoff_n;
      assign oe[g] = dv[g].miso_oe;
      assign mo[g] = dv[g].miso_o;
      chain_device_end i_chain_device_end (.i_core_clk, .i_rst,
         .i_clock_source_select(src), .i_frame_data(fd[g]), .link(dv[g]),
         .o_command(cmd[g]), .o_command_valid(cv[g]), .o_sample_strobe(ss[g]));
   end
   chain_host_end i_chain_host_end (.i_core_clk, .i_rst, .i_start,
      .i_tx(tx), .link(ifh), .o_rx(rx), .o_busy(busy), .o_done(done));
   chain_link_checker i_chain_link_checker (.i_core_clk, .i_rst,
      .sclk(ifh.sclk), .frame_sync(ifh.frame_sync),
      .chip_select_n(ifh.chip_select_n), .miso_oe(ifh.miso_oe));
   // External clock with a period of eight cycles.
   always @(negedge i_core_clk)
   begin
      flt <= ~flt;
      t <= t + 1;
      if (t % 4 == 0) ext <= ~ext;
   end
   // Captures commands and the spacing of sample pulses.
   always @(posedge i_core_clk)
   begin
      for (int k = 0; k < 4; k++) if (cv[k]) got[k] <= cmd[k];
      gap <= ss[0] ? 1 : gap + 1;
      if (ss[0]) last_gap <= gap;
   end
   function automatic logic [WORD_BITS-1:0] exp_cmd(int k);
      return tx[FRAME_BITS-1-k*DEVICE_BITS -: WORD_BITS];
   endfunction
   function automatic int exp_gap(int tick);
      return OVERSAMPLING_RATIO * tick;
   endfunction
   task automatic check(string what, logic [FRAME_BITS-1:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      if (n_mismatch == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // One whole frame; the corner case alternates all-ones and zero slots.
   task automatic frame(bit corner);
      int n;
      for (int k = 0; k < 4; k++)
      begin
         for (int i = 0; i < 18; i++) r = {r[FRAME_BITS-33:0], $random(seed)};
         fd[k] = corner ? {DEVICE_BITS{~k[0]}} : r[DEVICE_BITS-1:0];
      end
      tx = corner ? {FRAME_BITS{1'b1}} : r;
      i_start = 1;
      @(negedge i_core_clk);
      i_start = 0;
      for (n = 0; n < 4000 && done !== 1'b1; n++) @(negedge i_core_clk);
      if (n == 4000)
      begin
         n_mismatch++;
         final_report();
      end
      check("rx", rx, {fd[0], fd[1], fd[2], fd[3]});
      for (int k = 0; k < 4; k++) check("cmd", got[k], exp_cmd(k));
      repeat (16) @(negedge i_core_clk);
   endtask
   // Main sequence: frames, then the sample rate from both clock sources.
   initial
   begin
      for (int k = 0; k < 4; k++) fd[k] = '0;
      repeat (2) @(negedge i_core_clk);
      i_rst = 0;
      frame(1);
      repeat (3) frame(0);
      repeat (2200) @(negedge i_core_clk);
      check("rate", last_gap, exp_gap(2 * SCLK_HALF_CYCLES));
      src = 0;
      repeat (4300) @(negedge i_core_clk);
      check("rate", last_gap, exp_gap(8));
      final_report();
   end
   // Stops a hung run well after the expected span.
   initial
   begin
      #1000000;
      n_mismatch++;
      final_report();
   end
endmodule
`default_nettype wire
